/* core/link_shifter.sv */
`timescale 1ns/1ps
// ****************************************************************
// Link-side shifter, on the serial clock.
// ****************************************************************
module link_shifter
(
    // Link clock and strobes
    input wire logic lclk,
    input wire logic lrst,
    input wire logic frame_en,
    input wire logic msb_first,
    input wire logic [qsp_mode_pkg::FRAME_LEN_W-1:0] frame_bits_m1,
    input wire logic [qsp_mode_pkg::SER_WIDTH-1:0] load_word,
    input wire logic serial_in,
    // Results
    output logic serial_out,
    output logic frame_toggle,
    output logic [qsp_mode_pkg::SER_WIDTH-1:0] rx_word,
    output logic busy
);
    import qsp_mode_pkg::*;

    logic [SER_WIDTH-1:0] sh_q;
    logic [FRAME_LEN_W-1:0] cnt_q;
    logic done;
    logic [SER_WIDTH-1:0] shifted;
    logic rst_s1_q, rst_s2_q, en_s1_q, en_s2_q;

    // Reset and frame enable come from the system clock domain, so both
    // pass two flip-flops here before any link logic reads them.
    always_ff @(posedge lclk)
    begin
        rst_s1_q <= lrst;
        rst_s2_q <= rst_s1_q;
        en_s1_q <= frame_en;
        en_s2_q <= en_s1_q;
    end

    assign done = (cnt_q == frame_bits_m1);
    assign shifted = msb_first ? {sh_q[SER_WIDTH-2:0], serial_in}
                               : {serial_in, sh_q[SER_WIDTH-1:1]};

    always_ff @(posedge lclk)
    begin
        if (rst_s2_q || !en_s2_q)
        begin
            sh_q <= load_word;
            cnt_q <= BIT_CNT_ZERO;
            busy <= 1'b0;
            serial_out <= 1'b0;
        end
        else
        begin
            busy <= !done;
            serial_out <= msb_first ? sh_q[SER_WIDTH-1] : sh_q[0];
            sh_q <= done ? load_word : shifted;
            cnt_q <= done ? BIT_CNT_ZERO : cnt_q + BIT_CNT_ONE;
        end
    end

    always_ff @(posedge lclk)
    begin
        if (rst_s2_q)
        begin
            frame_toggle <= 1'b0;
            rx_word <= '0;
        end
        else if (en_s2_q && done)
        begin
            frame_toggle <= !frame_toggle;
            rx_word <= shifted;
        end
    end

endmodule

/* core/qsp_mode_pkg.sv */
package qsp_mode_pkg;

    // Configuration select encodings.
    typedef enum logic [1:0]
    {
        CFG_SPI = 2'h0,
        CFG_SER = 2'h1,
        CFG_COMBINED = 2'h2,
        CFG_RSVD = 2'h3
    } cfg_mode_t;

    localparam int ATTR_SEL_W = 3;
    localparam int FRAME_LEN_W = 4;
    localparam int SER_WIDTH = 16;
    localparam logic [ATTR_SEL_W-1:0] SLAVE_SPI_ATTR = 3'h0;
    localparam logic [ATTR_SEL_W-1:0] SLAVE_SER_ATTR = 3'h1;
    localparam logic [FRAME_LEN_W-1:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [FRAME_LEN_W-1:0] BIT_CNT_ONE = 4'h1;

endpackage

/* core/serial_port_mode_run_control.sv */
`timescale 1ns/1ps
// Summary of operation
// - Config field picks SPI, serializer or combined.
// - SPI master uses per-frame attribute select.
// - Combined mode arbitrates serializer versus SPI frames.
// - Master bit set makes device start frames itself; link clock is always an input.
// - Combined configuration allowed only as master.
// - Slave starts a frame only while select asserted; the frame then runs to its end.
// - Slave uses attribute zero SPI, one serializer.
// - Slave always shifts most significant bit first.
// - Module off blocks starts and stops the run state at a frame boundary.
// - Halt waits frame boundary, then acknowledges.
// - Halted device ignores traffic and register writes.
// - Debug with freeze bit stops transfers.
// - Debug request input enters debug mode.
// - Two states, reset stopped, stopped blocks transfers.
// - Running flag mirrors the running state.
// - Serializer moves up to sixteen parallel signals.
// - Start needs queue end clear, no halt, no freeze.
// - Stop at frame boundary, else next cycle.
// - Field value zero selects plain SPI.
module serial_port_mode_run_control
(
    // System clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control bits
    input wire logic [1:0] config_select_field,
    input wire logic master_select_bit,
    input wire logic module_off_bit,
    input wire logic freeze_on_debug_bit,
    input wire logic end_of_queue_flag,
    input wire logic reg_write,
    input wire logic [qsp_mode_pkg::ATTR_SEL_W-1:0]
        serializer_attribute_select,
    input wire logic [7:0] lsb_first_select,
    input wire logic [qsp_mode_pkg::FRAME_LEN_W-1:0] frame_bits_m1,
    // Queued command
    input wire logic cmd_valid,
    input wire logic [qsp_mode_pkg::ATTR_SEL_W-1:0] frame_attribute_select,
    input wire logic [qsp_mode_pkg::SER_WIDTH-1:0] cmd_data,
    // Power and debug
    input wire logic system_halt_request_reg,
    input wire logic clocks_restored,
    input wire logic debug_request,
    // Parallel serializer signals
    input wire logic [qsp_mode_pkg::SER_WIDTH-1:0] par_in,
    // Link side
    input wire logic sclk_link,
    input wire logic slave_select_n,
    input wire logic serial_in,
    // Outputs
    output logic serial_out,
    output logic transfer_running_flag,
    output logic halt_ack,
    output logic cmd_taken,
    output logic [qsp_mode_pkg::ATTR_SEL_W-1:0] active_attr,
    output logic active_is_ser,
    output logic [qsp_mode_pkg::SER_WIDTH-1:0] par_out,
    output logic [qsp_mode_pkg::SER_WIDTH-1:0] rx_data
);
    import qsp_mode_pkg::*;

    typedef enum logic {ST_STOPPED, ST_RUNNING} run_state_t;

    // ****************************************************************
    // Synchronisers and clock gating
    // ****************************************************************
    logic dbg_s1_q, dbg_s2_q, ssn_s1_q, ssn_s2_q;
    logic ft_s1_q, ft_s2_q, ft_s3_q, busy_s1_q, busy_s2_q;
    logic frame_toggle, link_busy;
    logic [SER_WIDTH-1:0] link_rx;
    logic core_en;
    logic halted_q;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
            ssn_s1_q <= 1'b1;
            ssn_s2_q <= 1'b1;
            ft_s1_q <= 1'b0;
            ft_s2_q <= 1'b0;
            ft_s3_q <= 1'b0;
            busy_s1_q <= 1'b0;
            busy_s2_q <= 1'b0;
        end
        else
        begin
            dbg_s1_q <= debug_request;
            dbg_s2_q <= dbg_s1_q;
            ssn_s1_q <= slave_select_n;
            ssn_s2_q <= ssn_s1_q;
            ft_s1_q <= frame_toggle;
            ft_s2_q <= ft_s1_q;
            ft_s3_q <= ft_s2_q;
            busy_s1_q <= link_busy;
            busy_s2_q <= busy_s1_q;
        end
    end

    // Clock gating is modelled as an enable so the design stays single
    // edge; the register inputs below it remain live.
    // module off gating
    assign core_en = !module_off_bit;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    cfg_mode_t cfg;
    logic cfg_legal, is_master, is_slave_sel, in_debug, freeze_now;
    logic frame_done, frame_active, boundary;

    assign cfg = cfg_mode_t'(config_select_field);
    assign cfg_legal = (cfg == CFG_SPI) || (cfg == CFG_SER)
                       || (cfg == CFG_COMBINED && master_select_bit);
    assign is_master = master_select_bit;
    assign is_slave_sel = !master_select_bit && !ssn_s2_q;
    assign in_debug = dbg_s2_q;
    assign freeze_now = in_debug && freeze_on_debug_bit;
    assign frame_done = ft_s2_q ^ ft_s3_q;
    assign frame_active = busy_s2_q;
    assign boundary = !frame_active || frame_done;

    // ****************************************************************
    // Run state machine
    // ****************************************************************
    run_state_t state_q, state_d;
    logic stop_req, start_ok;

    assign start_ok = !end_of_queue_flag && !system_halt_request_reg
                      && !freeze_now && core_en && cfg_legal;
    assign stop_req = !start_ok;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_STOPPED:
            begin
                if (start_ok)
                begin
                    state_d = ST_RUNNING;
                end
            end
            ST_RUNNING:
            begin
                if (stop_req && boundary)
                begin
                    state_d = ST_STOPPED;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= ST_STOPPED;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Halt handshake
    // ****************************************************************
    // acknowledge at boundary
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            halted_q <= 1'b0;
        end
        else if (halted_q)
        begin
            halted_q <= !clocks_restored;
        end
        else
        begin
            halted_q <= system_halt_request_reg && boundary;
        end
    end

    // ****************************************************************
    // Frame selection
    // ****************************************************************
    logic running, ser_turn, pick_ser, ser_change, start_frame;
    logic [ATTR_SEL_W-1:0] attr_d;
    logic [SER_WIDTH-1:0] ser_last_q, word_d, word_q;
    logic frame_en_q, msb_first_q, msb_d;

    assign running = (state_q == ST_RUNNING) && !halted_q;
    assign ser_change = (par_in != ser_last_q);
    assign ser_turn = (cfg == CFG_SER)
                      || (cfg == CFG_COMBINED && (ser_change || !cmd_valid));
    assign pick_ser = ser_turn;
    assign start_frame = running && boundary && !frame_en_q
                         && (is_master ? (pick_ser || cmd_valid)
                                       : is_slave_sel);

    assign attr_d = !is_master ? (cfg == CFG_SER ? SLAVE_SER_ATTR
                                                 : SLAVE_SPI_ATTR)
                    : pick_ser ? serializer_attribute_select
                    : frame_attribute_select;
    assign msb_d = !is_master || !lsb_first_select[attr_d];
    assign word_d = pick_ser ? par_in : cmd_data;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            frame_en_q <= 1'b0;
            msb_first_q <= 1'b1;
            word_q <= '0;
            ser_last_q <= '0;
            cmd_taken <= 1'b0;
            active_attr <= SLAVE_SPI_ATTR;
            active_is_ser <= 1'b0;
        end
        else
        begin
            cmd_taken <= start_frame && is_master && !pick_ser;
            if (start_frame)
            begin
                frame_en_q <= 1'b1;
                word_q <= word_d;
                msb_first_q <= msb_d;
                active_attr <= attr_d;
                active_is_ser <= !is_master ? (cfg == CFG_SER) : pick_ser;
                if (pick_ser)
                begin
                    ser_last_q <= par_in;
                end
            end
            else if (frame_done || !running)
            begin
                frame_en_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Status and results
    // ****************************************************************
    // halted ignores traffic
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            transfer_running_flag <= 1'b0;
            halt_ack <= 1'b0;
            par_out <= '0;
            rx_data <= '0;
        end
        else
        begin
            transfer_running_flag <= (state_d == ST_RUNNING);
            halt_ack <= halted_q;
            if (frame_done && !halted_q && !(reg_write && halted_q))
            begin
                rx_data <= link_rx;
                if (active_is_ser)
                begin
                    par_out <= link_rx;
                end
            end
        end
    end

    link_shifter u_link
    (
        .lclk(sclk_link),
        .lrst(srst),
        .frame_en(frame_en_q),
        .msb_first(msb_first_q),
        .frame_bits_m1(frame_bits_m1),
        .load_word(word_q),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .frame_toggle(frame_toggle),
        .rx_word(link_rx),
        .busy(link_busy)
    );

endmodule

/* dv/run_ctl_chk.sv */
`timescale 1ns/1ps
// ****************************************
// Run-control checker.
// ****************************************
module run_ctl_chk
    import qsp_mode_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Controls
    input wire logic [1:0] config_select_field,
    input wire logic master_select_bit,
    input wire logic module_off_bit,
    input wire logic freeze_on_debug_bit,
    input wire logic end_of_queue_flag,
    input wire logic system_halt_request_reg,
    input wire logic clocks_restored,
    input wire logic debug_request,
    input wire logic [qsp_mode_pkg::ATTR_SEL_W-1:0] frame_attribute_select,
    // Status
    input wire logic transfer_running_flag,
    input wire logic halt_ack,
    input wire logic cmd_taken,
    input wire logic [qsp_mode_pkg::ATTR_SEL_W-1:0] active_attr,
    input wire logic active_is_ser
);
    import qsp_mode_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_reset_stopped;
        $fell(srst) |-> !transfer_running_flag && !halt_ack && !cmd_taken;
    endproperty
    a_reset_stopped: assert property (p_reset_stopped)
        else $error("Outputs not idle after reset.");
    property p_taken_running;
        cmd_taken |-> $past(transfer_running_flag);
    endproperty
    a_taken_running: assert property (p_taken_running)
        else $error("Command taken while stopped.");
    // Any stop cause also forbids a start, so one check covers both.
    property p_no_start;
        !transfer_running_flag && (end_of_queue_flag || module_off_bit
            || system_halt_request_reg || config_select_field == CFG_RSVD)
            |=> !transfer_running_flag;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("Started despite a stop cause.");
    property p_stop_bound;
        transfer_running_flag && (end_of_queue_flag || module_off_bit)
            |-> ##[1:64] !transfer_running_flag;
    endproperty
    a_stop_bound: assert property (p_stop_bound)
        else $error("Stop not taken at frame end.");
    property p_freeze;
        (freeze_on_debug_bit && debug_request) [*3]
            |-> ##[0:64] !transfer_running_flag;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("Freeze did not stop transfers.");
    property p_ack_hold;
        halt_ack && !clocks_restored |=> halt_ack;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("Halt acknowledge dropped early.");
    property p_ack_release;
        halt_ack && clocks_restored |-> ##[1:2] !halt_ack;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("Halt acknowledge not released.");
    property p_ack_cause;
        $rose(halt_ack) |-> $past(system_halt_request_reg)
            && !transfer_running_flag;
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("Halt acknowledge without request.");
    property p_taken_pulse;
        cmd_taken |=> !cmd_taken;
    endproperty
    a_taken_pulse: assert property (p_taken_pulse)
        else $error("Command taken twice in a row.");
    property p_spi_attr;
        cmd_taken |-> active_attr == $past(frame_attribute_select)
            && !active_is_ser;
    endproperty
    a_spi_attr: assert property (p_spi_attr)
        else $error("Frame attribute not from command.");
    property p_combined_slave;
        (config_select_field == CFG_COMBINED && !master_select_bit) [*2]
            |-> !cmd_taken;
    endproperty
    a_combined_slave: assert property (p_combined_slave)
        else $error("Combined frame started as slave.");
endmodule

/* dv/spi_peer.sv */
`timescale 1ns/1ps
// ****************************************
// Far-side serial peer model.
// ****************************************
module spi_peer
(
    // Link clock enable
    input wire logic run,
    // Link pins
    output logic sclk,
    output logic sdo,
    input wire logic sdi
);
    logic [15:0] seen_q;
    initial
    begin
        sclk = 1'b0;
        sdo = 1'b0;
        #1.3;
        forever #6 sclk = run ? ~sclk : 1'b0;
    end
    always @(negedge sclk) sdo <= ~sdo;
    always @(posedge sclk) seen_q <= {seen_q[14:0], sdi};
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import qsp_mode_pkg::*;
    logic clk = 1'b0, srst = 1'b1, master_select_bit = 1'b1;
    logic module_off_bit = 1'b0, freeze_on_debug_bit = 1'b0;
    logic end_of_queue_flag = 1'b1, reg_write = 1'b0, cmd_valid = 1'b0;
    logic system_halt_request_reg = 1'b0, clocks_restored = 1'b0;
    logic debug_request = 1'b0, peer_run = 1'b1, slave_select_n = 1'b1;
    logic [1:0] config_select_field = 2'h0;
    logic [2:0] serializer_attribute_select = 3'h0;
    logic [2:0] frame_attribute_select = 3'h0;
    logic [7:0] lsb_first_select = 8'h00;
    logic [3:0] frame_bits_m1 = 4'hF;
    logic [15:0] cmd_data = 16'h0000, par_in = 16'h0000;
    logic sclk_link, serial_in, serial_out, transfer_running_flag;
    logic halt_ack, cmd_taken, active_is_ser;
    logic [2:0] active_attr, mon;
    logic [15:0] par_out, rx_data;
    int err_count = 0, num_checks = 0;
    assign mon = {cmd_taken, halt_ack, transfer_running_flag};
    always #4 clk = ~clk;
    spi_peer peer (.run(peer_run), .sclk(sclk_link), .sdo(serial_in),
        .sdi(serial_out));
    serial_port_mode_run_control dut (.clk, .srst, .config_select_field,
        .master_select_bit, .module_off_bit, .freeze_on_debug_bit,
        .end_of_queue_flag, .reg_write, .serializer_attribute_select,
        .lsb_first_select, .frame_bits_m1, .cmd_valid,
        .frame_attribute_select, .cmd_data, .system_halt_request_reg,
        .clocks_restored, .debug_request, .par_in, .sclk_link,
        .slave_select_n, .serial_in, .serial_out, .transfer_running_flag,
        .halt_ack, .cmd_taken, .active_attr, .active_is_ser,
        .par_out, .rx_data);
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bounded waits: a hung design shows as a mismatch, not a stall.
    task wait_for(input int idx, input logic exp);
        for (int n = 0; n < 200; n++)
        begin
            @(posedge clk);
            #1;
            if (mon[idx] === exp)
                break;
        end
        chk({15'h0, mon[idx]}, {15'h0, exp});
    endtask
    task wait_attr(input logic [2:0] a, input logic s);
        for (int n = 0; n < 200; n++)
        begin
            @(posedge clk);
            #1;
            if (active_attr === a && active_is_ser === s)
                break;
        end
        chk({12'h0, active_is_ser, active_attr}, {12'h0, s, a});
    endtask
    // frame types kept apart by their own attribute sets
    task cmd(input logic [2:0] a);
        @(posedge clk);
        frame_attribute_select <= a;
        cmd_data <= {4{1'b0, a}};
        cmd_valid <= 1'b1;
        wait_for(2, 1'b1);
        chk({12'h0, active_is_ser, active_attr}, {13'h0, a});
        @(posedge clk) cmd_valid <= 1'b0;
        repeat (40) @(posedge clk);
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        peer_run <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({13'h0, mon}, 16'h0000);
        @(posedge clk) end_of_queue_flag <= 1'b0;
        wait_for(0, 1'b1);
        $display("test start done");
        @(posedge clk) peer_run <= 1'b1;
        for (int a = 0; a < 8; a++)
            cmd(a[2:0]);
        chk({1'b0, rx_data[14:0] ^ rx_data[15:1]}, 16'h7FFF);
        $display("test spi master done");
        @(posedge clk);
        config_select_field <= 2'h1;
        serializer_attribute_select <= 3'h5;
        par_in <= 16'hA5A5;
        wait_attr(3'h5, 1'b1);
        @(posedge clk) config_select_field <= 2'h2;
        cmd(3'h3);
        wait_attr(3'h5, 1'b1);
        chk({1'b0, par_out[14:0] ^ par_out[15:1]}, 16'h7FFF);
        $display("test serializer done");
        @(posedge clk) end_of_queue_flag <= 1'b1;
        wait_for(0, 1'b0);
        @(posedge clk);
        end_of_queue_flag <= 1'b0;
        master_select_bit <= 1'b0;
        config_select_field <= 2'h0;
        lsb_first_select <= 8'hFF;
        slave_select_n <= 1'b0;
        wait_attr(3'h0, 1'b0);
        @(posedge clk) config_select_field <= 2'h1;
        wait_attr(3'h1, 1'b1);
        @(posedge clk) config_select_field <= 2'h2;
        repeat (40) @(posedge clk);
        master_select_bit <= 1'b1;
        config_select_field <= 2'h0;
        slave_select_n <= 1'b1;
        $display("test slave done");
        @(posedge clk) system_halt_request_reg <= 1'b1;
        wait_for(1, 1'b1);
        chk({15'h0, transfer_running_flag}, 16'h0000);
        @(posedge clk) system_halt_request_reg <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk({15'h0, halt_ack}, 16'h0001);
        @(posedge clk) clocks_restored <= 1'b1;
        wait_for(1, 1'b0);
        @(posedge clk) clocks_restored <= 1'b0;
        wait_for(0, 1'b1);
        $display("test halt done");
        @(posedge clk);
        freeze_on_debug_bit <= 1'b1;
        debug_request <= 1'b1;
        wait_for(0, 1'b0);
        @(posedge clk) debug_request <= 1'b0;
        wait_for(0, 1'b1);
        @(posedge clk);
        freeze_on_debug_bit <= 1'b0;
        debug_request <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk({15'h0, transfer_running_flag}, 16'h0001);
        @(posedge clk) debug_request <= 1'b0;
        $display("test freeze done");
        @(posedge clk) module_off_bit <= 1'b1;
        wait_for(0, 1'b0);
        @(posedge clk) module_off_bit <= 1'b0;
        wait_for(0, 1'b1);
        @(posedge clk) end_of_queue_flag <= 1'b1;
        wait_for(0, 1'b0);
        @(posedge clk);
        end_of_queue_flag <= 1'b0;
        config_select_field <= 2'h3;
        repeat (5) @(posedge clk);
        #1;
        chk({15'h0, transfer_running_flag}, 16'h0000);
        $display("test stop done");
        wrap_up();
    end
endmodule
bind serial_port_mode_run_control run_ctl_chk chk (.clk, .srst,
    .config_select_field, .master_select_bit, .module_off_bit,
    .freeze_on_debug_bit, .end_of_queue_flag, .system_halt_request_reg,
    .clocks_restored, .debug_request, .frame_attribute_select,
    .transfer_running_flag, .halt_ack, .cmd_taken, .active_attr,
    .active_is_ser);
